// ### rtl/parity_ctl_pkg.sv
// parity control package: field positions, reset values and sense encodings
// assumes a single 10 MHz clock domain
package parity_ctl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LANES = 4;
  // bit positions within the control, status and test registers
  localparam int unsigned CTL_FIRST_ATN_BIT = 1;
  localparam int unsigned CTL_FIRST_GEN_BIT = 2;
  localparam int unsigned CTL_FIRST_CHK_BIT = 3;
  localparam int unsigned CTL_SECOND_EVEN_BIT = 2;
  localparam int unsigned IRQ_EN_PAR_BIT = 0;
  localparam int unsigned STAT_FIRST_PERR_BIT = 0;
  localparam int unsigned STAT_SECOND_LIVE_BIT = 0;
  localparam int unsigned STAT_THIRD_LATCH_BIT = 3;
  localparam int unsigned TEST_DMA_PAR_BIT = 3;
  localparam int unsigned TEST_SCSI_PAR_BIT = 4;
  localparam int unsigned TEST_CTL_DMA_PAR_BIT = 3;
  localparam int unsigned TEST_CTL_HOST_EVEN_BIT = 2;
  // reset values
  localparam logic PERR_RESET = 1'b0;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic FIFO_PAR_RESET = 1'b0;
  localparam logic HALT_RESET = 1'b0;
  localparam logic IRQ_RESET = 1'b0;
  localparam logic ATN_RESET = 1'b0;
  // scsi parity line is active low, so idle is high
  localparam logic LINE_N_RESET = 1'b1;
  localparam logic HPAR_RESET = 1'b0;
  typedef enum logic {
    SENSE_ODD_type_val = 1'b0,
    SENSE_EVEN_type_val = 1'b1
  } sense_type;
endpackage

// ### rtl/parity_bit_gen.sv
// one-byte parity generator and checker
// assumes sense select is static during the byte
`timescale 1ns/100ps
module parity_bit_gen #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data_i,
  input wire logic even_i,
  input wire logic par_i,
  output logic par_o,
  output logic bad_o
);
  logic ones;
  always_comb begin
    ones = ^data_i;
    // odd sense: total ones including parity must be odd
    par_o = even_i ? ones : ~ones;
    if (even_i) begin
      bad_o = ones ^ par_i;
    end else begin
      bad_o = ~(ones ^ par_i);
    end
  end
endmodule // parity_bit_gen

// ### rtl/scsi_parity_control.sv
// parity generation, pass-through, checking and error reactions
// assumes inputs synchronous to CLK_I; byte strobes are one-cycle pulses
//
// Operation
// - as initiator with attention bit set, a parity error asserts attention
// - generate bit picks own scsi parity or pass-through from host
// - check enable gates all error detection; sense follows even select
// - even select sets driven and checked scsi sense; zero means odd
// - halt control stops the device on target-role parity error
// - parity interrupt enable gates the interrupt request
// - error flag reads one after any checked scsi or host parity error
// - live bit shows one while active-low scsi parity line is asserted
// - latched bit captures parity line at first byte of a phase
// - dma fifo test read places its parity bit into test status
// - write-only test bit supplies parity stored with dma test writes
// - scsi fifo test read places its parity bit into test status
// - host even bit inverts parity between scsi and host sides
// - without generation, parity passes through both directions, inverted only when host even is set
// - with generation, host parity ignored and not driven when receiving
// - checking covers received scsi bytes and host bytes being sent
// - with checking off, no parity errors are reported
// - reactions need checking; both controls zero gives no halt or irq
// - checking and interrupt enable raise interrupt in both roles
// - halt control halts target only; irq only with interrupt enable
// - both set: halt on target error, interrupt in either role
`timescale 1ns/100ps
module scsi_parity_control
  import parity_ctl_pkg::*;
#(
  parameter int unsigned LANE_N = LANES
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PARITY_GENERATE_EN_I,
  input wire logic PARITY_CHECK_EN_I,
  input wire logic ATN_ON_ERROR_EN_I,
  input wire logic EVEN_SENSE_SELECT_I,
  input wire logic HALT_ON_ERROR_CTL_I,
  input wire logic PARITY_IRQ_EN_I,
  input wire logic HOST_EVEN_I,
  input wire logic INITIATOR_I,
  input wire logic SENDING_I,
  input wire logic [1:0] LANE_SEL_I,
  input wire logic [7:0] SEND_DATA_I,
  input wire logic SEND_STB_I,
  input wire logic [LANE_N-1:0] HOST_LANE_PARITY_I,
  input wire logic [7:0] RECV_DATA_I,
  input wire logic RECV_STB_I,
  input wire logic FIRST_BYTE_STB_I,
  input wire logic SCSI_PARITY_LINE_N_I,
  output logic SCSI_PARITY_LINE_N_O,
  output logic SCSI_PARITY_LINE_OE_O,
  output logic [LANE_N-1:0] HOST_LANE_PARITY_O,
  output logic [LANE_N-1:0] HOST_LANE_PARITY_OE_O,
  input wire logic PERR_CLEAR_I,
  output logic PARITY_ERROR_O,
  output logic LIVE_PARITY_O,
  output logic LATCHED_PARITY_O,
  output logic ATN_ASSERT_O,
  output logic HALT_O,
  input wire logic HALT_RESTART_I,
  output logic IRQ_O,
  input wire logic DMA_TEST_PARITY_I,
  input wire logic DMA_TEST_WRITE_I,
  output logic DMA_FIFO_WR_PAR_O,
  input wire logic DMA_TEST_READ_I,
  input wire logic DMA_FIFO_RD_PAR_I,
  output logic DMA_TEST_PAR_O,
  input wire logic SCSI_TEST_READ_I,
  input wire logic SCSI_FIFO_RD_PAR_I,
  output logic SCSI_TEST_PAR_O
);
  logic gen_par, send_bad;
  logic recv_par_calc, recv_bad;
  logic host_par_in, recv_par_pos;
  logic err_now;
  logic perr_q, perr_d;
  logic latch_q, latch_d;
  logic halt_q, halt_d;
  logic atn_q, atn_d;
  logic irq_q, irq_d;
  logic dma_q, dma_d;
  logic scsi_q, scsi_d;
  logic dma_wr_q, dma_wr_d;
  logic [LANE_N-1:0] hpar_q, hpar_d;
  logic sdp_q, sdp_d;

  // host lane parity, flipped to scsi sense when the host runs even
  always_comb begin
    host_par_in = HOST_LANE_PARITY_I[LANE_SEL_I] ^ HOST_EVEN_I;
    recv_par_pos = ~SCSI_PARITY_LINE_N_I;
  end

  // checker on the outgoing host byte against selected scsi sense
  parity_bit_gen #(
    .WIDTH(BYTE_W)
  ) u_send (
    .data_i(SEND_DATA_I),
    .even_i(EVEN_SENSE_SELECT_I),
    .par_i(host_par_in),
    .par_o(gen_par),
    .bad_o(send_bad)
  );

  parity_bit_gen #(
    .WIDTH(BYTE_W)
  ) u_recv (
    .data_i(RECV_DATA_I),
    .even_i(EVEN_SENSE_SELECT_I),
    .par_i(recv_par_pos),
    .par_o(recv_par_calc),
    .bad_o(recv_bad)
  );

  always_comb begin
    // host parity is only meaningful in pass-through
    err_now = PARITY_CHECK_EN_I & (
      (RECV_STB_I & recv_bad) |
      (SEND_STB_I & send_bad & ~PARITY_GENERATE_EN_I));
  end

  // outgoing scsi parity and host lane parity
  always_comb begin
    sdp_d = sdp_q;
    hpar_d = hpar_q;
    if (SEND_STB_I) begin
      sdp_d = ~(PARITY_GENERATE_EN_I ? gen_par : host_par_in);
    end
    if (RECV_STB_I) begin
      hpar_d = {LANE_N{recv_par_pos ^ HOST_EVEN_I}};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sdp_q <= LINE_N_RESET;
      hpar_q <= {LANE_N{HPAR_RESET}};
    end else begin
      sdp_q <= sdp_d;
      hpar_q <= hpar_d;
    end
  end

  always_comb begin
    SCSI_PARITY_LINE_N_O = sdp_q;
    SCSI_PARITY_LINE_OE_O = SENDING_I;
    HOST_LANE_PARITY_O = hpar_q;
    HOST_LANE_PARITY_OE_O = {LANE_N{~SENDING_I & ~PARITY_GENERATE_EN_I}};
  end

  // error flag, reactions and status
  always_comb begin
    perr_d = perr_q;
    if (PERR_CLEAR_I) begin
      perr_d = 1'b0;
    end
    if (err_now) begin
      perr_d = 1'b1;
    end
    halt_d = halt_q;
    if (HALT_RESTART_I) begin
      halt_d = 1'b0;
    end
    if (err_now & HALT_ON_ERROR_CTL_I & ~INITIATOR_I) begin
      halt_d = 1'b1;
    end
    irq_d = irq_q;
    if (PERR_CLEAR_I) begin
      irq_d = 1'b0;
    end
    if (err_now & PARITY_IRQ_EN_I) begin
      irq_d = 1'b1;
    end
    atn_d = atn_q;
    if (~INITIATOR_I | PERR_CLEAR_I) begin
      atn_d = 1'b0;
    end
    if (err_now & ATN_ON_ERROR_EN_I & INITIATOR_I) begin
      atn_d = 1'b1;
    end
    latch_d = FIRST_BYTE_STB_I ? ~SCSI_PARITY_LINE_N_I : latch_q;
    dma_d = DMA_TEST_READ_I ? DMA_FIFO_RD_PAR_I : dma_q;
    scsi_d = SCSI_TEST_READ_I ? SCSI_FIFO_RD_PAR_I : scsi_q;
    dma_wr_d = DMA_TEST_WRITE_I ? DMA_TEST_PARITY_I : dma_wr_q;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      perr_q <= PERR_RESET;
      halt_q <= HALT_RESET;
      irq_q <= IRQ_RESET;
      atn_q <= ATN_RESET;
      latch_q <= LATCH_RESET;
      dma_q <= FIFO_PAR_RESET;
      scsi_q <= FIFO_PAR_RESET;
      dma_wr_q <= FIFO_PAR_RESET;
    end else begin
      perr_q <= perr_d;
      halt_q <= halt_d;
      irq_q <= irq_d;
      atn_q <= atn_d;
      latch_q <= latch_d;
      dma_q <= dma_d;
      scsi_q <= scsi_d;
      dma_wr_q <= dma_wr_d;
    end
  end

  always_comb begin
    PARITY_ERROR_O = perr_q;
    LIVE_PARITY_O = ~SCSI_PARITY_LINE_N_I;
    LATCHED_PARITY_O = latch_q;
    ATN_ASSERT_O = atn_q;
    HALT_O = halt_q;
    IRQ_O = irq_q;
    DMA_TEST_PAR_O = dma_q;
    SCSI_TEST_PAR_O = scsi_q;
    DMA_FIFO_WR_PAR_O = dma_wr_q;
  end

  // several-step error paths are built from named sequences
  sequence s_bad_recv;
    RECV_STB_I && PARITY_CHECK_EN_I && recv_bad;
  endsequence
  sequence s_bad_send;
    SEND_STB_I && PARITY_CHECK_EN_I && send_bad && !PARITY_GENERATE_EN_I;
  endsequence

  a_perr_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    err_now |=> PARITY_ERROR_O) else $error("error flag not set");
  a_no_check: assert property (@(posedge CLK_I) disable iff (RST_I)
    !PARITY_CHECK_EN_I && !PARITY_ERROR_O && !PERR_CLEAR_I |=> !PARITY_ERROR_O)
    else $error("error without checking");
  a_halt_tgt: assert property (@(posedge CLK_I) disable iff (RST_I)
    err_now && HALT_ON_ERROR_CTL_I && !INITIATOR_I |=> HALT_O)
    else $error("no halt on target error");
  a_irq_en: assert property (@(posedge CLK_I) disable iff (RST_I)
    err_now && PARITY_IRQ_EN_I |=> IRQ_O) else $error("no irq");
  a_no_irq: assert property (@(posedge CLK_I) disable iff (RST_I)
    !IRQ_O && !(err_now && PARITY_IRQ_EN_I) |=> !IRQ_O)
    else $error("spurious irq");
  a_atn_init: assert property (@(posedge CLK_I) disable iff (RST_I)
    err_now && ATN_ON_ERROR_EN_I && INITIATOR_I |=> ATN_ASSERT_O)
    else $error("no attention");
  a_latch_cap: assert property (@(posedge CLK_I) disable iff (RST_I)
    FIRST_BYTE_STB_I |=> LATCHED_PARITY_O == !$past(SCSI_PARITY_LINE_N_I))
    else $error("latched parity wrong");
  a_dma_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    DMA_TEST_READ_I |=> DMA_TEST_PAR_O == $past(DMA_FIFO_RD_PAR_I))
    else $error("dma parity wrong");
  a_scsi_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    SCSI_TEST_READ_I |=> SCSI_TEST_PAR_O == $past(SCSI_FIFO_RD_PAR_I))
    else $error("scsi parity wrong");
  a_gen_undrv: assert property (@(posedge CLK_I) disable iff (RST_I)
    PARITY_GENERATE_EN_I |-> HOST_LANE_PARITY_OE_O == '0)
    else $error("host parity driven");
  a_recv_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_bad_recv ##1 !PERR_CLEAR_I |-> PARITY_ERROR_O ##1 PARITY_ERROR_O)
    else $error("receive error not flagged and held");
  a_send_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_bad_send |=> PARITY_ERROR_O) else $error("host error not flagged");
  a_gen_masks: assert property (@(posedge CLK_I) disable iff (RST_I)
    SEND_STB_I && PARITY_GENERATE_EN_I && !RECV_STB_I && !PARITY_ERROR_O |=> !PARITY_ERROR_O)
    else $error("host parity checked while generating");
  a_perr_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    PARITY_ERROR_O && !PERR_CLEAR_I |=> PARITY_ERROR_O) else $error("error flag lost");
  a_irq_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    IRQ_O && !PERR_CLEAR_I |=> IRQ_O) else $error("irq dropped");
  a_no_chk_irq: assert property (@(posedge CLK_I) disable iff (RST_I)
    !PARITY_CHECK_EN_I && !IRQ_O |=> !IRQ_O)
    else $error("irq without checking");
  a_halt_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    HALT_O && !HALT_RESTART_I |=> HALT_O) else $error("halt dropped");
  a_init_nohalt: assert property (@(posedge CLK_I) disable iff (RST_I)
    !HALT_O && INITIATOR_I |=> !HALT_O)
    else $error("halt in initiator role");
  a_atn_quiet: assert property (@(posedge CLK_I) disable iff (RST_I)
    !ATN_ASSERT_O && !(err_now && ATN_ON_ERROR_EN_I && INITIATOR_I) |=> !ATN_ASSERT_O)
    else $error("spurious attention");
  a_tgt_noatn: assert property (@(posedge CLK_I) disable iff (RST_I)
    !INITIATOR_I |=> !ATN_ASSERT_O) else $error("attention in target role");
  a_line_gen: assert property (@(posedge CLK_I) disable iff (RST_I)
    SEND_STB_I && PARITY_GENERATE_EN_I |=>
    (^$past(SEND_DATA_I) ^ !SCSI_PARITY_LINE_N_O) != $past(EVEN_SENSE_SELECT_I))
    else $error("generated parity wrong");
  a_line_pass: assert property (@(posedge CLK_I) disable iff (RST_I)
    SEND_STB_I && !PARITY_GENERATE_EN_I |=>
    !SCSI_PARITY_LINE_N_O == ($past(HOST_LANE_PARITY_I[LANE_SEL_I]) ^ $past(HOST_EVEN_I)))
    else $error("passed parity wrong");
  a_host_recv: assert property (@(posedge CLK_I) disable iff (RST_I)
    RECV_STB_I |=>
    HOST_LANE_PARITY_O == {LANE_N{!$past(SCSI_PARITY_LINE_N_I) ^ $past(HOST_EVEN_I)}})
    else $error("host lane parity wrong");
  a_dma_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    DMA_TEST_WRITE_I |=> DMA_FIFO_WR_PAR_O == $past(DMA_TEST_PARITY_I))
    else $error("dma write parity wrong");
  a_line_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !SEND_STB_I |=> $stable(SCSI_PARITY_LINE_N_O)) else $error("scsi parity moved");
  a_host_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RECV_STB_I |=> $stable(HOST_LANE_PARITY_O)) else $error("host parity moved");
  a_latch_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !FIRST_BYTE_STB_I |=> $stable(LATCHED_PARITY_O)) else $error("latched parity moved");
endmodule // scsi_parity_control

// ### dv/scsi_dev_model.sv
// far-side scsi device: drives the parity line for bytes it sends us
// assumes the line is terminated high when nobody drives it
`timescale 1ns/100ps
module scsi_dev_model (
  input wire logic [7:0] data_i,
  input wire logic even_i,
  input wire logic corrupt_i,
  input wire logic drive_i,
  input wire logic host_oe_i,
  input wire logic host_n_i,
  output logic line_n_o
);
  logic par;
  // corrupt only when the bench asks for a bad byte
  assign par = ^data_i ^ ~even_i ^ corrupt_i;
  // released line floats to the terminator level
  assign line_n_o = host_oe_i ? host_n_i : (drive_i ? ~par : 1'b1);
endmodule // scsi_dev_model

// ### dv/tb.sv
// self-checking bench for the parity control block
// assumes the scsi device model in dv and the design package
`timescale 1ns/100ps
module tb;
  import parity_ctl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, gen = 1'b0, chk = 1'b0, atn = 1'b0, evn = 1'b0;
  logic hlt = 1'b0, ien = 1'b0, hev = 1'b0, ini = 1'b0, snd = 1'b0, sstb = 1'b0;
  logic rstb = 1'b0, fstb = 1'b0, clr = 1'b0, rsta = 1'b0, bad = 1'b0, drv = 1'b0;
  logic dtp = 1'b0, dtw = 1'b0, dtr = 1'b0, dfp = 1'b0, str = 1'b0, sfp = 1'b0;
  logic [1:0] lsel = 2'h0;
  logic [7:0] sdat = 8'h00, rdat = 8'h00;
  logic [3:0] hpar = 4'h0;
  logic [7:0] pats [4] = '{8'h00, 8'h01, 8'hA5, 8'h7F};
  wire line_n, pl_n, pl_oe, perr, live, lat, atn_o, halt, irq, dwp, dtpo, stpo;
  wire [3:0] hp_o, hp_oe;
  int fail_count = 0;
  int n_checks = 0;
  scsi_parity_control uut (.CLK_I(clk), .RST_I(rst), .PARITY_GENERATE_EN_I(gen),
    .PARITY_CHECK_EN_I(chk), .ATN_ON_ERROR_EN_I(atn), .EVEN_SENSE_SELECT_I(evn),
    .HALT_ON_ERROR_CTL_I(hlt), .PARITY_IRQ_EN_I(ien), .HOST_EVEN_I(hev), .INITIATOR_I(ini),
    .SENDING_I(snd), .LANE_SEL_I(lsel), .SEND_DATA_I(sdat), .SEND_STB_I(sstb),
    .HOST_LANE_PARITY_I(hpar), .RECV_DATA_I(rdat), .RECV_STB_I(rstb), .FIRST_BYTE_STB_I(fstb),
    .SCSI_PARITY_LINE_N_I(line_n), .SCSI_PARITY_LINE_N_O(pl_n), .SCSI_PARITY_LINE_OE_O(pl_oe),
    .HOST_LANE_PARITY_O(hp_o), .HOST_LANE_PARITY_OE_O(hp_oe), .PERR_CLEAR_I(clr),
    .PARITY_ERROR_O(perr), .LIVE_PARITY_O(live), .LATCHED_PARITY_O(lat), .ATN_ASSERT_O(atn_o),
    .HALT_O(halt), .HALT_RESTART_I(rsta), .IRQ_O(irq), .DMA_TEST_PARITY_I(dtp),
    .DMA_TEST_WRITE_I(dtw), .DMA_FIFO_WR_PAR_O(dwp), .DMA_TEST_READ_I(dtr),
    .DMA_FIFO_RD_PAR_I(dfp), .DMA_TEST_PAR_O(dtpo), .SCSI_TEST_READ_I(str),
    .SCSI_FIFO_RD_PAR_I(sfp), .SCSI_TEST_PAR_O(stpo));
  scsi_dev_model dev (.data_i(rdat), .even_i(evn), .corrupt_i(bad), .drive_i(drv),
    .host_oe_i(pl_oe), .host_n_i(pl_n), .line_n_o(line_n));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic cmp(string nm, logic [3:0] e, logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(logic [7:0] d);
    @(posedge clk);
    sdat <= d;
    snd <= 1'b1;
    sstb <= 1'b1;
    @(posedge clk);
    sstb <= 1'b0;
    #1;
  endtask
  task automatic recv(logic [7:0] d, logic b);
    @(posedge clk);
    rdat <= d;
    bad <= b;
    snd <= 1'b0;
    drv <= 1'b1;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    drv <= 1'b0;
    #1;
  endtask
  task automatic clear_all;
    @(posedge clk);
    clr <= 1'b1;
    rsta <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    rsta <= 1'b0;
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp("reset", 4'h1, {perr, halt, irq, pl_n});
    // host pins carry wrong parity for some patterns to prove they are ignored
    @(posedge clk);
    gen <= 1'b1;
    chk <= 1'b1;
    hpar <= 4'hF;
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      evn <= 1'(e);
      for (int i = 0; i < 4; i++) begin
        send(pats[i]);
        cmp("gen_line", 4'(^pats[i] ^ e[0]), 4'(pl_n));
        cmp("line_oe", 4'h1, 4'(pl_oe));
      end
    end
    recv(8'h01, 1'b0);
    cmp("gen_host_oe", 4'h0, hp_oe);
    cmp("gen_perr", 4'h0, 4'(perr));
    cmp("line_oe_rx", 4'h0, 4'(pl_oe));
    @(posedge clk);
    {gen, chk, hlt, ien, ini, evn} <= 6'b000110;
    for (int l = 0; l < 8; l++) begin
      @(posedge clk);
      hpar <= 4'hA;
      lsel <= l[1:0];
      hev <= l[2];
      send(8'h00);
      cmp("pass_send", 4'(!(l[0] ^ l[2])), 4'(pl_n));
      cmp("pass_oe_send", 4'h0, hp_oe);
      recv(8'h01, 1'b1);
      cmp("pass_recv", {4{~l[2]}}, hp_o);
      cmp("pass_oe", 4'hF, hp_oe);
      cmp("no_check", 4'h0, 4'({perr, halt, irq}));
    end
    @(posedge clk);
    chk <= 1'b1;
    hev <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      {atn, ini, hlt, ien} <= 4'(k);
      clear_all();
      cmp("cleared", 4'h0, {perr, halt, irq, atn_o});
      recv(8'h3C, 1'b0);
      cmp("good_byte", 4'h0, 4'(perr));
      recv(8'h3C, 1'b1);
      repeat (3) @(posedge clk);
      cmp("react", {1'b1, hlt & ~ini, ien, atn & ini}, {perr, halt, irq, atn_o});
    end
    @(posedge clk);
    {atn, ini, hlt, ien, evn} <= 5'b00001;
    clear_all();
    recv(8'h3C, 1'b0);
    cmp("even_good", 4'h0, 4'(perr));
    recv(8'h3C, 1'b1);
    cmp("even_bad", 4'h1, 4'(perr));
    // host-even inversion is exercised on the checked send path too
    for (int h = 0; h < 4; h++) begin
      @(posedge clk);
      evn <= 1'b0;
      lsel <= 2'h2;
      hev <= h[1];
      hpar <= {1'b0, h[0], 2'b00};
      clear_all();
      send(8'h00);
      cmp("host_err", 4'(!(h[0] ^ h[1])), 4'(perr));
    end
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      snd <= 1'b0;
      drv <= 1'b1;
      rdat <= 8'(v);
      bad <= 1'b0;
      fstb <= 1'b1;
      dtp <= v[0];
      dfp <= v[0];
      sfp <= v[0];
      {dtw, dtr, str} <= 3'h7;
      @(posedge clk);
      fstb <= 1'b0;
      {dtw, dtr, str} <= 3'h0;
      #1;
      cmp("live_lat", {2'b00, live, lat}, {2'b00, ~v[0], ~v[0]});
      cmp("fifo_par", 4'({dwp, dtpo, stpo}), {1'b0, {3{v[0]}}});
    end
    complete_run();
  end
endmodule // tb
